/* File: design/rsc_cfg.svh */
`ifndef RSC_CFG_SVH
`define RSC_CFG_SVH
// Register word indexes; the byte address is four times the index
`define RSC_IDX_CTRL 6'h00
`define RSC_IDX_RDSYNC 6'h02
`define RSC_IDX_EVOUT 6'h04
`define RSC_IDX_IRQCLR 6'h06
`define RSC_IDX_IRQSET 6'h07
`define RSC_IDX_FLAG 6'h08
`define RSC_IDX_STATUS 6'h0a
`define RSC_IDX_COUNT 6'h10
// Field positions
`define RSC_BIT_SINGLE 15
`define RSC_BIT_CONT 14
`define RSC_BIT_OVERFLOW_IE 7
`define RSC_BIT_READY_IE 6
`define RSC_BIT_BUSY 7
`define RSC_BIT_OVERFLOW_EO 15
`define RSC_BIT_CTRL_EN 1
`define RSC_BIT_CTRL_SWRST 0
// Reset values
`define RSC_RST_RDSYNC 16'h0010
`define RSC_SEL_CONST 6'h10
`define RSC_RST_EVOUT 16'h0000
`define RSC_RST_IRQEN 8'h00
`define RSC_RST_FLAG 8'h00
`define RSC_RST_CTRL 16'h0000
// Writable bit masks
`define RSC_EV_MASK_WIDE 16'h81ff
`define RSC_EV_MASK_NARROW 16'h83ff
`define RSC_IE_MASK_WIDE 8'hc1
`define RSC_IE_MASK_NARROW 8'hc3
// Timing: sync stages (two flops each way)
`define RSC_SYNC_STAGES 3'h4
`endif

/* File: design/rsc_pkg.sv */
package rsc_pkg;
	typedef enum logic [1:0] {
		RSC_MODE_WIDE,
		RSC_MODE_NARROW,
		RSC_MODE_CAL,
		RSC_MODE_RSVD
	} rsc_mode_t;

	typedef struct packed {
		logic overflow;
		logic [1:0] compare;
		logic [7:0] periodic;
	} rsc_evt_t;

	typedef enum {
		RSC_IDLE,
		RSC_BUSY
	} rsc_sync_st_t;
endpackage

/* File: design/rsc_sync_engine.sv */
`timescale 1ns/1ns
`include "rsc_cfg.svh"
// Read synchronization: copies the counter value into a bus-side shadow.
module rsc_sync_engine #(
	parameter int DW = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic [DW-1:0] count_value,
	output logic busy,
	output logic done,
	output logic [DW-1:0] shadow
);
	rsc_pkg::rsc_sync_st_t st_q;
	rsc_pkg::rsc_sync_st_t st_d;
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;
	logic busy_q;
	logic done_q;
	logic [DW-1:0] shadow_q;
	wire last = (cnt_q == `RSC_SYNC_STAGES - 3'h1);

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			rsc_pkg::RSC_IDLE: begin
				cnt_d = 3'h0;
				if (start)
					st_d = rsc_pkg::RSC_BUSY;
			end
			rsc_pkg::RSC_BUSY: begin
				cnt_d = cnt_q + 3'h1;
				if (abort)
					st_d = rsc_pkg::RSC_IDLE;
				else if (last)
					st_d = rsc_pkg::RSC_IDLE;
			end
			default: st_d = rsc_pkg::RSC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= rsc_pkg::RSC_IDLE;
			cnt_q <= 3'h0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			shadow_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			busy_q <= (st_d == rsc_pkg::RSC_BUSY);
			done_q <= (st_q == rsc_pkg::RSC_BUSY) && last && !abort;
			if (st_q == rsc_pkg::RSC_BUSY && last)
				shadow_q <= count_value;
		end
	end

	assign busy = busy_q;
	assign done = done_q;
	assign shadow = shadow_q;
endmodule // rsc_sync_engine

/* File: design/rsc_ctrl.sv */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "rsc_cfg.svh"
// Function
// - Writing one to bit 15 starts a sync and sets busy; zero does nothing.
// - Bit 14 set resyncs the counter on every update; zero stops it.
// - While continuous is on, single-shot request stays pending after sync.
// - Any register write except one to sync control byte 1 clears the continuous sync bit.
// - Select field bits 5:0 is read-only constant 0x10.
// - Sync control resets to 0x0010; request write-only, continuous RW.
// - Overflow event enable bit 15 gates overflow events in all modes.
// - Bit 8 enables compare 0 (wide); bits 9,8 compare 1,0 (narrow).
// - Calendar mode bit 8 gates alarm 0 events.
// - Bits 7:0 individually enable eight periodic interval events.
// - Event control is 16 bits at 0x04, reset 0x0000, read-write.
// - Writing one to clear bit 7 disables overflow interrupt.
// - Writing one to clear bit 6 disables sync-ready interrupt.
// - Writing one to compare bits clears compare interrupt enables.
// - Calendar mode clear bit 0 disables alarm 0 interrupt.
// - Enable reads back; enabled flag raises interrupt request.
// - Interrupt enable clear is 8 bits at 0x06, reset 0x00.
// - Busy status sets at sync start and clears at completion.
// - Set register shares enables; writing one sets, zero ignored.
// - Sync-ready flag sets on busy falling, except on enable or reset.
module rsc_ctrl #(
	parameter int CW = 32
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic [CW-1:0] count_value,
	input wire logic count_update,
	input wire rsc_pkg::rsc_evt_t evt_raw,
	output rsc_pkg::rsc_evt_t evt_out,
	input wire rsc_pkg::rsc_evt_t flag_set,
	output logic irq,
	output logic [1:0] mode
);
	// =========================================================
	// Bus decode
	// =========================================================
	logic ack_q;
	logic err_q;
	logic [31:0] rdat_q;
	wire req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire [5:0] idx = wb_adr_i[7:2];
	wire aligned = (wb_adr_i[1:0] == 2'b00);

	// One-hot register select; an unknown index selects nothing
	function automatic logic [7:0] reg_select(input logic [5:0] i);
		logic [7:0] s;
		s = 8'h00;
		if (i == `RSC_IDX_CTRL)
			s[0] = 1'b1;
		else if (i == `RSC_IDX_RDSYNC)
			s[1] = 1'b1;
		else if (i == `RSC_IDX_EVOUT)
			s[2] = 1'b1;
		else if (i == `RSC_IDX_IRQCLR)
			s[3] = 1'b1;
		else if (i == `RSC_IDX_IRQSET)
			s[4] = 1'b1;
		else if (i == `RSC_IDX_FLAG)
			s[5] = 1'b1;
		else if (i == `RSC_IDX_STATUS)
			s[6] = 1'b1;
		else if (i == `RSC_IDX_COUNT)
			s[7] = 1'b1;
		return s;
	endfunction

	// Misaligned byte addresses fall through to an error answer
	wire [7:0] hit = aligned ? reg_select(idx) : 8'h00;
	wire hit_ctrl = hit[0];
	wire hit_rds = hit[1];
	wire hit_ev = hit[2];
	wire hit_clr = hit[3];
	wire hit_set = hit[4];
	wire hit_flag = hit[5];
	wire hit_stat = hit[6];
	wire hit_cnt = hit[7];
	wire mapped = |hit;
	wire wr = req && wb_we_i && mapped;

	function automatic logic [31:0] lanes(input logic [31:0] oldv,
		input logic [31:0] newv, input logic [3:0] sel);
		logic [31:0] r;
		r = oldv;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = newv[i*8 +: 8];
		return r;
	endfunction

	function automatic logic [31:0] ones(input logic [31:0] v,
		input logic [3:0] sel);
		logic [31:0] r;
		r = '0;
		for (int i = 0; i < 4; i++)
			if (sel[i])
				r[i*8 +: 8] = v[i*8 +: 8];
		return r;
	endfunction

	wire [31:0] wones = ones(wb_dat_i, wb_sel_i);

	// Writable and visible bits follow the mode; the reserved mode keeps
	// the wide layout so that no stray enable survives there
	function automatic logic [15:0] ev_mask_of(input logic [1:0] m);
		logic [15:0] r;
		if (m == 2'(rsc_pkg::RSC_MODE_NARROW))
			r = `RSC_EV_MASK_NARROW;
		else
			r = `RSC_EV_MASK_WIDE;
		return r;
	endfunction

	function automatic logic [7:0] ie_mask_of(input logic [1:0] m);
		logic [7:0] r;
		if (m == 2'(rsc_pkg::RSC_MODE_NARROW))
			r = `RSC_IE_MASK_NARROW;
		else
			r = `RSC_IE_MASK_WIDE;
		return r;
	endfunction

	// =========================================================
	// Control (mode, enable, software reset)
	// =========================================================
	logic [15:0] ctrl_q;
	wire [31:0] ctrl_new = lanes({16'h0000, ctrl_q}, wb_dat_i, wb_sel_i);
	wire swrst = wr && hit_ctrl && ctrl_new[`RSC_BIT_CTRL_SWRST];
	wire en_chg = wr && hit_ctrl &&
		(ctrl_new[`RSC_BIT_CTRL_EN] != ctrl_q[`RSC_BIT_CTRL_EN]);
	wire srst = rst || swrst;
	wire [1:0] cur_mode = ctrl_q[3:2];
	wire is_narrow = (cur_mode == 2'(rsc_pkg::RSC_MODE_NARROW));

	always_ff @(posedge clk) begin
		if (srst)
			ctrl_q <= `RSC_RST_CTRL;
		else if (wr && hit_ctrl)
			ctrl_q <= {ctrl_new[15:1], 1'b0};
	end

	// =========================================================
	// Read synchronization control
	// =========================================================
	logic cont_q;
	logic single_q;
	logic upd_pend_q;
	logic sync_busy;
	logic sync_done;
	logic [CW-1:0] shadow;
	logic busy_was_q;
	wire single_wr = wr && hit_rds && wones[`RSC_BIT_SINGLE];
	wire cont_wr = wr && hit_rds && wb_sel_i[1];
	wire start = !sync_busy && (single_wr ||
		(single_q && !cont_q) || (cont_q && upd_pend_q));

	always_ff @(posedge clk) begin
		if (srst) begin
			cont_q <= 1'b0;
			single_q <= 1'b0;
			upd_pend_q <= 1'b0;
		end else begin
			// Explicit write of the bit wins over the any-write clear
			if (cont_wr)
				cont_q <= wb_dat_i[`RSC_BIT_CONT];
			else if (wr)
				cont_q <= 1'b0;
			// Outside continuous mode, a request taken by this start is consumed, not left pending
			if (start && !cont_q)
				single_q <= 1'b0;
			else if (single_wr)
				single_q <= 1'b1;
			else if (sync_done && !cont_q)
				single_q <= 1'b0;
			// Update that lands while busy is kept for the next round
			if (count_update && cont_q)
				upd_pend_q <= 1'b1;
			else if (start)
				upd_pend_q <= 1'b0;
		end
	end

	rsc_sync_engine #(
		.DW(CW)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.start(start),
		.abort(swrst),
		.count_value(count_value),
		.busy(sync_busy),
		.done(sync_done),
		.shadow(shadow)
	);

	// Software reset also ends a busy period; neither it nor an enable change raises a flag
	logic quiet_q;
	always_ff @(posedge clk) begin
		if (rst) begin
			busy_was_q <= 1'b0;
			quiet_q <= 1'b0;
		end else begin
			busy_was_q <= sync_busy;
			quiet_q <= swrst || en_chg;
		end
	end
	wire sync_ready_irq_evt = busy_was_q && !sync_busy &&
		!quiet_q && !swrst;

	// =========================================================
	// Event output control
	// =========================================================
	logic [15:0] ev_q;
	wire [15:0] ev_mask = ev_mask_of(cur_mode);
	wire [31:0] ev_new = lanes({16'h0000, ev_q}, wb_dat_i, wb_sel_i);
	wire [15:0] ev_view = ev_q & ev_mask;

	always_ff @(posedge clk) begin
		if (srst)
			ev_q <= `RSC_RST_EVOUT;
		else if (wr && hit_ev)
			ev_q <= ev_new[15:0] & ev_mask;
	end

	// One gate per periodic interval output
	wire [7:0] per_gated;
	for (genvar g = 0; g < 8; g++) begin : g_per
		assign per_gated[g] = evt_raw.periodic[g] && ev_q[g];
	end
	// Wide and calendar modes share bit 8; narrow adds bit 9
	wire ovf_gated = evt_raw.overflow &&
		ev_q[`RSC_BIT_OVERFLOW_EO];
	wire compare0_irq_gated = evt_raw.compare[0] && ev_q[8];
	wire cmp1_gated = evt_raw.compare[1] && ev_q[9] &&
		is_narrow;

	rsc_pkg::rsc_evt_t evt_q;
	always_ff @(posedge clk) begin
		if (rst)
			evt_q <= '0;
		else
			evt_q <= {ovf_gated, cmp1_gated, compare0_irq_gated, per_gated};
	end

	// =========================================================
	// Interrupt enables and flags
	// =========================================================
	logic [7:0] ie_q;
	logic [7:0] flag_q;
	wire [7:0] ie_mask = ie_mask_of(cur_mode);
	wire [7:0] clr_bits = (wr && hit_clr) ? (wones[7:0] & ie_mask) : 8'h00;
	wire [7:0] set_bits = (wr && hit_set) ? (wones[7:0] & ie_mask) : 8'h00;
	wire [7:0] hw_flags = {flag_set.overflow, sync_ready_irq_evt, 4'h0,
		flag_set.compare[1] && is_narrow, flag_set.compare[0]};
	wire [7:0] flag_clr = (wr && hit_flag) ? wones[7:0] : 8'h00;
	wire [7:0] ie_d;
	wire [7:0] flag_d;

	// Clear and set sit at different indexes, so one write never does both
	for (genvar b = 0; b < 8; b++) begin : g_irq_bit
		assign ie_d[b] = set_bits[b] || (ie_q[b] && !clr_bits[b]);
		// Hardware set wins over a same-cycle software clear
		assign flag_d[b] = hw_flags[b] || (flag_q[b] && !flag_clr[b]);
	end
	// Bits of another mode stay stored but are neither shown nor used
	wire [7:0] ie_view = ie_q & ie_mask;
	wire [7:0] flag_view = flag_q & ie_mask;

	always_ff @(posedge clk) begin
		if (srst) begin
			ie_q <= `RSC_RST_IRQEN;
			flag_q <= `RSC_RST_FLAG;
		end else begin
			ie_q <= ie_d;
			flag_q <= flag_d;
		end
	end

	logic irq_q;
	always_ff @(posedge clk) begin
		if (rst)
			irq_q <= 1'b0;
		else
			irq_q <= |(ie_view & flag_view);
	end

	// =========================================================
	// Read mux and acknowledge
	// =========================================================
	wire [15:0] rds_view = {1'b0, cont_q, 8'h00,
		`RSC_SEL_CONST};
	wire [31:0] rd_mux =
		hit_ctrl ? {16'h0000, ctrl_q} :
		hit_rds ? {16'h0000, rds_view} :
		hit_ev ? {16'h0000, ev_view} :
		(hit_clr || hit_set) ? {24'h000000, ie_view} :
		hit_flag ? {24'h000000, flag_view} :
		hit_stat ? {24'h000000, sync_busy, 7'h00} :
		hit_cnt ? 32'(shadow) : 32'h00000000;

	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ack_q <= req && mapped;
			err_q <= req && !mapped;
			rdat_q <= (req && !wb_we_i) ? rd_mux : 32'h00000000;
		end
	end

	logic [1:0] mode_q;
	always_ff @(posedge clk) begin
		if (rst)
			mode_q <= 2'h0;
		else
			mode_q <= cur_mode;
	end

	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdat_q;
	assign evt_out = evt_q;
	assign irq = irq_q;
	assign mode = mode_q;
endmodule // rsc_ctrl

/* File: verification/rsc_ctrl_chk.sv */
`timescale 1ns/1ns
// ============
// Port checks
module rsc_ctrl_chk #(parameter int CW = 32) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire rsc_pkg::rsc_evt_t evt_raw,
	input wire rsc_pkg::rsc_evt_t evt_out,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	property p_ans; req |=> wb_ack_o || wb_err_o; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_one; wb_ack_o |=> !wb_ack_o; endproperty
	a_one: assert property (p_one) else $error("long ack");
	property p_bad; req && wb_adr_i[1:0] != 2'h0 |=> wb_err_o; endproperty
	a_bad: assert property (p_bad) else $error("no err");
	property p_dz; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_dz: assert property (p_dz) else $error("stray data");
	property p_sel;
		wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h08)
		|-> wb_dat_o[5:0] == 6'h10 && wb_dat_o[31:16] == 16'h0;
	endproperty
	a_sel: assert property (p_sel) else $error("bad select");
	// An event may only leave one cycle after its raw pulse
	property p_evt; (evt_out & ~$past(evt_raw)) == 11'h0; endproperty
	a_evt: assert property (p_evt) else $error("bad event");
	property p_clr;
		wb_ack_o && $past(wb_we_i && wb_adr_i == 8'h18 && wb_dat_i[7:0] == 8'hff)
		|-> ##[1:2] !irq;
	endproperty
	a_clr: assert property (p_clr) else $error("irq stays");
	property p_ie;
		wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h18)
		|-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_ie: assert property (p_ie) else $error("wide enable");
endmodule // rsc_ctrl_chk

bind rsc_ctrl rsc_ctrl_chk #(.CW(CW)) u_chk (.clk, .rst, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.wb_err_o, .evt_raw, .evt_out, .irq);

/* File: verification/rsc_far_model.sv */
`timescale 1ns/1ns
// ============
// Counter and event system stand-in
module rsc_far_model (
	input wire logic clk,
	input wire rsc_pkg::rsc_evt_t evt_out,
	output logic [31:0] count_value,
	output logic count_update,
	output rsc_pkg::rsc_evt_t evt_raw,
	output rsc_pkg::rsc_evt_t flag_set
);
	rsc_pkg::rsc_evt_t seen = '0;
	initial begin
		count_value = 32'h0;
		count_update = 1'b0;
		evt_raw = '0;
		flag_set = '0;
	end
	always @(posedge clk) begin
		if (evt_out != '0) seen <= evt_out;
	end
	task automatic bump(input logic [31:0] v);
		@(posedge clk);
		count_value <= v;
		count_update <= 1'b1;
		@(posedge clk);
		count_update <= 1'b0;
	endtask
	task automatic fire(input rsc_pkg::rsc_evt_t e, input logic f);
		@(posedge clk);
		seen <= '0;
		if (f) flag_set <= e;
		else evt_raw <= e;
		@(posedge clk);
		flag_set <= '0;
		evt_raw <= '0;
	endtask
endmodule // rsc_far_model

/* File: verification/tb_rsc_readsync_event_irq_ctrl.sv */
`timescale 1ns/1ns
// ============
// Scenarios
module tb_rsc_readsync_event_irq_ctrl;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h0;
	logic [3:0] sel = 4'hf;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o, rd, cv;
	logic ack, err, er, irq, cu;
	logic [1:0] mode;
	rsc_pkg::rsc_evt_t raw, eo, fs;
	int n_fail = 0;
	int n_compared = 0;
	always #25 clk = ~clk;
	rsc_ctrl dut (.clk, .rst, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .wb_err_o(err), .count_value(cv),
		.count_update(cu), .evt_raw(raw), .evt_out(eo), .flag_set(fs),
		.irq, .mode);
	rsc_far_model u_p (.clk, .evt_out(eo), .count_value(cv),
		.count_update(cu), .evt_raw(raw), .flag_set(fs));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && err !== 1'b1 && k < 20);
		rd = dat_o;
		er = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) chk(32'h0, 32'h1);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd & m, e);
	endtask
	task automatic t_reset;
		rdc(8'h08, 32'hffffffff, 32'h10);
		rdc(8'h10, 32'hffffffff, 32'h0);
		rdc(8'h18, 32'hffffffff, 32'h0);
		bus(1'b1, 8'h09, 32'hffff);
		chk({31'h0, er}, 32'h1);
	endtask
	task automatic t_sync;
		int k;
		u_p.bump(32'h5a5a0f0f);
		bus(1'b1, 8'h08, 32'h8000);
		rdc(8'h28, 32'h80, 32'h80);
		k = 0;
		do begin
			bus(1'b0, 8'h28, 32'h0);
			k++;
		end while (rd[7] && k < 10);
		chk({31'h0, rd[7]}, 32'h0);
		rdc(8'h40, 32'hffffffff, 32'h5a5a0f0f);
		rdc(8'h20, 32'h40, 32'h40);
	endtask
	task automatic t_cont;
		bus(1'b1, 8'h08, 32'h4000);
		rdc(8'h08, 32'h7fff, 32'h4010);
		u_p.bump(32'hbeef);
		// Sync takes four cycles; eight leaves margin
		repeat (8) @(posedge clk);
		rdc(8'h40, 32'hffffffff, 32'hbeef);
		bus(1'b1, 8'h20, 32'hff);
		rdc(8'h08, 32'h4000, 32'h0);
		u_p.bump(32'h1);
		repeat (8) @(posedge clk);
		rdc(8'h40, 32'hffffffff, 32'hbeef);
	endtask
	task automatic t_evt;
		logic [15:0] v;
		rsc_pkg::rsc_evt_t e;
		for (int m = 0; m < 3; m++) begin
			bus(1'b1, 8'h00, {28'h0, m[1:0], 2'h0});
			// The mode copy trails the control write by one edge
			@(posedge clk);
			chk({30'h0, mode}, m);
			for (int i = 0; i < 2; i++) begin
				v = i ? 16'h8255 : 16'hffff;
				bus(1'b1, 8'h10, {16'h0, v});
				e = {v[15], (m == 1) ? v[9] : 1'b0, v[8], v[7:0]};
				rdc(8'h10, 32'hffff, {16'h0, e[10], 5'h0, e[9:0]});
				u_p.fire('1, 1'b0);
				repeat (2) @(posedge clk);
				chk({21'h0, u_p.seen}, {21'h0, e});
			end
		end
	endtask
	task automatic t_irq;
		bus(1'b1, 8'h00, 32'h4);
		bus(1'b1, 8'h1c, 32'hff);
		rdc(8'h18, 32'hff, 32'hc3);
		bus(1'b1, 8'h18, 32'h0);
		rdc(8'h18, 32'hff, 32'hc3);
		bus(1'b1, 8'h18, 32'h41);
		rdc(8'h18, 32'hff, 32'h82);
		u_p.fire(11'h400, 1'b1);
		repeat (3) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 8'h18, 32'h80);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h00, 32'h8);
		bus(1'b1, 8'h1c, 32'hff);
		rdc(8'h18, 32'hff, 32'hc1);
		bus(1'b1, 8'h18, 32'hff);
		rdc(8'h18, 32'hff, 32'h0);
	endtask
	task automatic final_report;
		$display("Compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_sync();
		t_cont();
		t_evt();
		t_irq();
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report();
	end
endmodule // tb_rsc_readsync_event_irq_ctrl
